/* hdl/ifbio_expander.v */
`timescale 1ns/10ps
`include "ifbio_regs.vh"

module ifbio_expander (
   input wire core_clk,
   input wire rst_n,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   input wire gp_pin_zero_in,
   output wire gp_pin_zero_out,
   output wire gp_pin_zero_oe,
   input wire gp_pin_one_in,
   output wire gp_pin_one_out,
   output wire gp_pin_one_oe,
   input wire gp_pin_two_in,
   output wire gp_pin_two_out,
   output wire gp_pin_two_oe,
   input wire gp_pin_three_in,
   output wire gp_pin_three_out,
   output wire gp_pin_three_oe
);

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_ADDR_ACK = 4'h2;
   localparam [3:0] ST_CMD = 4'h3;
   localparam [3:0] ST_CMD_ACK = 4'h4;
   localparam [3:0] ST_WDATA = 4'h5;
   localparam [3:0] ST_WDATA_ACK = 4'h6;
   localparam [3:0] ST_RDATA = 4'h7;
   localparam [3:0] ST_RACK = 4'h8;
   localparam [3:0] ST_IGNORE = 4'h9;
   localparam integer FILT_CYC_INT = `IFBIO_FILT_CYC;
   localparam [`IFBIO_FILT_W-1:0] FILT_LIMIT = FILT_CYC_INT[`IFBIO_FILT_W-1:0];

   reg [7:0] pin_drive_latch_reg;
   reg [7:0] input_invert_select_reg;
   reg [7:0] pin_direction_select_reg;
   reg [1:0] pointer_reg;
   reg [3:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg [7:0] tx_reg;
   reg read_dir_reg;
   reg scl_f_reg;
   reg sda_f_reg;
   reg scl_d_reg;
   reg sda_d_reg;
   reg [`IFBIO_FILT_W-1:0] scl_cnt_reg;
   reg [`IFBIO_FILT_W-1:0] sda_cnt_reg;

   wire [3:0] pin_raw;
   wire [7:0] pin_level_input;
   wire [7:0] read_value;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;

   // next value of a glitch filter counter: counts while raw differs
   function [`IFBIO_FILT_W-1:0] ifbio_filt_cnt;
      input raw;
      input filtered;
      input [`IFBIO_FILT_W-1:0] cnt;
      begin
         if (raw == filtered) begin
            ifbio_filt_cnt = {`IFBIO_FILT_W{1'b0}};
         end else if (cnt == FILT_LIMIT - 1'b1) begin
            ifbio_filt_cnt = {`IFBIO_FILT_W{1'b0}};
         end else begin
            ifbio_filt_cnt = cnt + 1'b1;
         end
      end
   endfunction

   // register read selection
   function [7:0] ifbio_read_sel;
      input [1:0] ptr;
      input [7:0] lvl;
      input [7:0] drv;
      input [7:0] inv;
      input [7:0] dir;
      begin
         case (ptr)
            `IFBIO_PTR_PIN_LEVEL_INPUT: ifbio_read_sel = lvl;
            `IFBIO_PTR_PIN_DRIVE_LATCH: ifbio_read_sel = drv;
            `IFBIO_PTR_INPUT_INVERT_SELECT: ifbio_read_sel = inv;
            default: ifbio_read_sel = dir;
         endcase
      end
   endfunction

   assign pin_raw = {gp_pin_three_in, gp_pin_two_in, gp_pin_one_in, gp_pin_zero_in};
   // live pins, even those driven by us; upper nibble fixed high
   assign pin_level_input = {`IFBIO_INPUT_UPPER_FILL,
      pin_raw ^ input_invert_select_reg[3:0]};
   assign read_value = ifbio_read_sel(pointer_reg, pin_level_input, pin_drive_latch_reg,
      input_invert_select_reg, pin_direction_select_reg);

   // open-drain data line: only ever pulled low
   assign sda_out = 1'b0;

   // latch bit drives only while the pin is an output
   assign gp_pin_zero_out = pin_drive_latch_reg[0];
   assign gp_pin_one_out = pin_drive_latch_reg[1];
   assign gp_pin_two_out = pin_drive_latch_reg[2];
   assign gp_pin_three_out = pin_drive_latch_reg[3];
   assign gp_pin_zero_oe = ~pin_direction_select_reg[0];
   assign gp_pin_one_oe = ~pin_direction_select_reg[1];
   assign gp_pin_two_oe = ~pin_direction_select_reg[2];
   assign gp_pin_three_oe = ~pin_direction_select_reg[3];

   // edges and conditions seen on the filtered lines only
   assign scl_rise = scl_f_reg & ~scl_d_reg;
   assign scl_fall = ~scl_f_reg & scl_d_reg;
   assign start_det = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
   assign stop_det = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;

   // a level must persist past the spike width before it is believed;
   // costs one extra sample of latency, fine below 1 MHz bus clocks
   always @(posedge core_clk) begin
      if (!rst_n) begin
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         scl_cnt_reg <= {`IFBIO_FILT_W{1'b0}};
         sda_cnt_reg <= {`IFBIO_FILT_W{1'b0}};
      end else begin
         scl_cnt_reg <= ifbio_filt_cnt(scl_in, scl_f_reg, scl_cnt_reg);
         sda_cnt_reg <= ifbio_filt_cnt(sda_in, sda_f_reg, sda_cnt_reg);
         if (scl_in != scl_f_reg && scl_cnt_reg == FILT_LIMIT - 1'b1) begin
            scl_f_reg <= scl_in;
         end
         if (sda_in != sda_f_reg && sda_cnt_reg == FILT_LIMIT - 1'b1) begin
            sda_f_reg <= sda_in;
         end
         scl_d_reg <= scl_f_reg;
         sda_d_reg <= sda_f_reg;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         read_dir_reg <= 1'b0;
         sda_oe <= 1'b0;
         pointer_reg <= `IFBIO_RST_POINTER;
         pin_drive_latch_reg <= `IFBIO_RST_PIN_DRIVE_LATCH;
         input_invert_select_reg <= `IFBIO_RST_INPUT_INVERT_SELECT;
         pin_direction_select_reg <= `IFBIO_RST_PIN_DIRECTION_SELECT;
      end else if (stop_det) begin
         state_reg <= ST_IDLE;
         sda_oe <= 1'b0;
      end else if (start_det) begin
         // repeated start also lands here; pointer is kept
         state_reg <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe <= 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_f_reg};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == `IFBIO_BITS_PER_BYTE) begin
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (shift_reg[7:1] == `IFBIO_SLAVE_ADDR) begin
                        sda_oe <= 1'b1;
                        read_dir_reg <= shift_reg[`IFBIO_RW_BIT];
                        state_reg <= ST_ADDR_ACK;
                     end else begin
                        state_reg <= ST_IGNORE;
                     end
                  end else if (state_reg == ST_CMD) begin
                     sda_oe <= 1'b1;
                     state_reg <= ST_CMD_ACK;
                  end else begin
                     sda_oe <= 1'b1;
                     state_reg <= ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (read_dir_reg == `IFBIO_READ_DIR) begin
                     tx_reg <= {read_value[6:0], 1'b0};
                     sda_oe <= ~read_value[7];
                     state_reg <= ST_RDATA;
                  end else begin
                     sda_oe <= 1'b0;
                     state_reg <= ST_CMD;
                  end
               end
            end
            ST_CMD_ACK: begin
               if (scl_fall) begin
                  // upper command bits are not decoded
                  pointer_reg <= shift_reg[1:0];
                  sda_oe <= 1'b0;
                  state_reg <= ST_WDATA;
               end
            end
            ST_WDATA_ACK: begin
               if (scl_fall) begin
                  // store at end of ack so pins move after it
                  case (pointer_reg)
                     `IFBIO_PTR_PIN_DRIVE_LATCH: pin_drive_latch_reg <= shift_reg;
                     `IFBIO_PTR_INPUT_INVERT_SELECT: input_invert_select_reg <= shift_reg;
                     `IFBIO_PTR_PIN_DIRECTION_SELECT: pin_direction_select_reg <= shift_reg;
                     default: pin_drive_latch_reg <= pin_drive_latch_reg;
                  endcase
                  sda_oe <= 1'b0;
                  state_reg <= ST_WDATA; // pointer held
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_reg == `IFBIO_BITS_PER_BYTE) begin
                     bit_cnt_reg <= 4'h0;
                     sda_oe <= 1'b0;
                     state_reg <= ST_RACK;
                  end else begin
                     sda_oe <= ~tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'b0};
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  // master not acknowledging ends the read
                  read_dir_reg <= ~sda_f_reg;
               end else if (scl_fall) begin
                  if (read_dir_reg) begin
                     // same register again
                     tx_reg <= {read_value[6:0], 1'b0};
                     sda_oe <= ~read_value[7];
                     state_reg <= ST_RDATA;
                  end else begin
                     state_reg <= ST_IGNORE;
                  end
               end
            end
            ST_IDLE, ST_IGNORE: begin
               sda_oe <= 1'b0;
            end
            default: begin
               state_reg <= ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

endmodule // ifbio_expander

/* pkg/ifbio_regs.vh */
`ifndef IFBIO_REGS_VH
`define IFBIO_REGS_VH

// register pointer values carried by the command byte
`define IFBIO_PTR_PIN_LEVEL_INPUT 2'h0
`define IFBIO_PTR_PIN_DRIVE_LATCH 2'h1
`define IFBIO_PTR_INPUT_INVERT_SELECT 2'h2
`define IFBIO_PTR_PIN_DIRECTION_SELECT 2'h3

// reset values
`define IFBIO_RST_PIN_DRIVE_LATCH 8'hFF
`define IFBIO_RST_INPUT_INVERT_SELECT 8'h00
`define IFBIO_RST_PIN_DIRECTION_SELECT 8'hFF
`define IFBIO_RST_POINTER 2'h0

// field layout of the input register
`define IFBIO_INPUT_UPPER_FILL 4'hF
`define IFBIO_PIN_COUNT 4

// fixed seven-bit slave address and direction bit position
`define IFBIO_SLAVE_ADDR 7'h41
`define IFBIO_RW_BIT 0
`define IFBIO_READ_DIR 1'h1

// timing
`define IFBIO_CLK_PERIOD_NS 100
`define IFBIO_SPIKE_NS 50
`define IFBIO_SPIKE_CYC ((`IFBIO_SPIKE_NS + `IFBIO_CLK_PERIOD_NS - 1) / `IFBIO_CLK_PERIOD_NS)
`define IFBIO_FILT_CYC (`IFBIO_SPIKE_CYC + 1)
`define IFBIO_FILT_W 3

// serial byte
`define IFBIO_BITS_PER_BYTE 4'h8

`endif

/* verification/ifbio_master.sv */
`timescale 1ns/10ps
module ifbio_master (
   input wire core_clk,
   input wire sda_in,
   output logic scl,
   output logic sda_low
);
   localparam int Q = 25; // quarter bit at 100 kHz
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hold();
      repeat (Q) @(posedge core_clk);
   endtask
   // data moves only while scl low, sampled mid high
   task automatic bit_io(input logic b, output logic r);
      sda_low <= ~b;
      hold();
      scl <= 1'b1;
      hold();
      r = sda_in;
      hold();
      scl <= 1'b0;
      hold();
   endtask
   task automatic start();
      sda_low <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda_low <= 1'b1;
      hold();
      scl <= 1'b0;
      hold();
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      sda_low <= 1'b0;
      hold();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(output logic [7:0] d, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule // ifbio_master

/* verification/ifbio_chk_sva.sv */
`timescale 1ns/10ps
module ifbio_chk (
   input wire core_clk,
   input wire rst_n,
   input wire scl_in,
   input wire sda_in,
   input wire sda_oe,
   input wire gp_pin_zero_out,
   input wire gp_pin_zero_oe,
   input wire gp_pin_one_out,
   input wire gp_pin_one_oe,
   input wire gp_pin_two_out,
   input wire gp_pin_two_oe,
   input wire gp_pin_three_out,
   input wire gp_pin_three_oe
);
   wire [7:0] pins = {gp_pin_three_oe, gp_pin_two_oe, gp_pin_one_oe, gp_pin_zero_oe,
      gp_pin_three_out, gp_pin_two_out, gp_pin_one_out, gp_pin_zero_out};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_pin_upd_low: assert property ($changed(pins) |-> !scl_in && !$past(scl_in, 2))
      else $error("pin moved with scl high");
   chk_pin_after_ack: assert property ($changed(pins) |-> $past(sda_oe, 3))
      else $error("pin moved without ack");
   chk_reset_dflt: assert property (!$past(rst_n) |-> !sda_oe && pins == 8'h0F)
      else $error("outputs not at defaults after reset");
   chk_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
      else $error("drive began with scl high");
   chk_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data drive moved while scl high");
   chk_drive_min: assert property ($rose(sda_oe) |-> sda_oe[*8])
      else $error("drive too short");
   chk_drive_bound: assert property (sda_oe |-> ##[1:1000] !sda_oe)
      else $error("data line held too long");
   chk_stop_quiet: assert property (scl_in && $rose(sda_in) |-> (!sda_oe)[*8])
      else $error("drive after stop");
endmodule // ifbio_chk
bind ifbio_expander ifbio_chk i_chk (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in),
   .sda_in(sda_in), .sda_oe(sda_oe), .gp_pin_zero_out(gp_pin_zero_out),
   .gp_pin_zero_oe(gp_pin_zero_oe), .gp_pin_one_out(gp_pin_one_out),
   .gp_pin_one_oe(gp_pin_one_oe), .gp_pin_two_out(gp_pin_two_out),
   .gp_pin_two_oe(gp_pin_two_oe), .gp_pin_three_out(gp_pin_three_out),
   .gp_pin_three_oe(gp_pin_three_oe));

/* verification/ifbio_expander_tb.sv */
`timescale 1ns/10ps
`include "ifbio_regs.vh"
module ifbio_expander_tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] ext = 4'h5;
   logic [7:0] lat, inv, dir, got;
   logic [1:0] ptr;
   logic ack;
   wire scl, sda_low, sda_oe, sda_out;
   wire [3:0] pin_in, pin_out, pin_oe;
   wire sda_in = ~(sda_low | sda_oe); // pulled up when nobody pulls
   int mismatches, num_checks;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
   ifbio_expander i_dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .gp_pin_zero_in(pin_in[0]), .gp_pin_zero_out(pin_out[0]),
      .gp_pin_zero_oe(pin_oe[0]), .gp_pin_one_in(pin_in[1]), .gp_pin_one_out(pin_out[1]),
      .gp_pin_one_oe(pin_oe[1]), .gp_pin_two_in(pin_in[2]), .gp_pin_two_out(pin_out[2]),
      .gp_pin_two_oe(pin_oe[2]), .gp_pin_three_in(pin_in[3]), .gp_pin_three_out(pin_out[3]),
      .gp_pin_three_oe(pin_oe[3]));
   ifbio_master i_mst (.core_clk(core_clk), .sda_in(sda_in), .scl(scl), .sda_low(sda_low));
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] expv(input logic [1:0] p);
      logic [3:0] lv;
      lv = (~dir[3:0] & lat[3:0]) | (dir[3:0] & ext);
      case (p)
         2'h0: expv = {4'hF, lv ^ inv[3:0]};
         2'h1: expv = lat;
         2'h2: expv = inv;
         default: expv = dir;
      endcase
   endfunction
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      lat = 8'hFF;
      inv = 8'h00;
      dir = 8'hFF;
      ptr = 2'h0;
   endtask
   // command byte, then n data bytes; the last one sent is d
   task automatic wr(input logic [1:0] p, input logic [7:0] d, input int n);
      i_mst.start();
      i_mst.wbyte({`IFBIO_SLAVE_ADDR, 1'b0}, ack);
      chk({7'h0, ack}, 8'h01);
      i_mst.wbyte({6'h0, p}, ack);
      for (int k = n - 1; k >= 0; k--) i_mst.wbyte(d ^ k[7:0], ack);
      i_mst.stop();
      ptr = p;
      if (n > 0 && p == 2'h1) lat = d;
      if (n > 0 && p == 2'h2) inv = d;
      if (n > 0 && p == 2'h3) dir = d;
      chk({pin_oe, pin_out}, {~dir[3:0], lat[3:0]});
      chk({7'h0, sda_out}, 8'h00);
   endtask
   task automatic rd(input int n);
      i_mst.start();
      i_mst.wbyte({`IFBIO_SLAVE_ADDR, 1'b1}, ack);
      chk({7'h0, ack}, 8'h01);
      for (int k = 1; k <= n; k++) begin
         i_mst.rbyte(got, k == n);
         chk(got, expv(ptr));
      end
      i_mst.stop();
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #10000000;
      mismatches++;
      test_done();
   end
   initial begin
      void'($urandom(32'h9DE0));
      do_reset();
      rd(1);
      for (int p = 1; p < 4; p++) begin
         wr(p[1:0], 8'h00, 0);
         rd(1);
      end
      $display("defaults done");
      repeat (2) begin
         for (int p = 1; p < 4; p++) wr(p[1:0], $urandom, 1);
         wr(2'h0, $urandom, 1);
         @(posedge core_clk) ext <= $urandom;
         rd(1);
         wr(2'h1, 8'h00, 0);
         rd(2);
      end
      $display("random access done");
      wr(2'h1, $urandom, 3);
      rd(2);
      $display("burst done");
      // one-sample low spike on scl in the middle of the first address bit
      fork
         wr(2'h2, 8'hA5, 1);
         begin
            repeat (150) @(posedge core_clk);
            i_mst.scl <= 1'b0;
            @(posedge core_clk) i_mst.scl <= 1'b1;
         end
      join
      rd(1);
      $display("spike done");
      i_mst.start();
      i_mst.wbyte({7'h40, 1'b0}, ack);
      chk({7'h0, ack}, 8'h00);
      i_mst.wbyte(8'h02, ack);
      i_mst.stop();
      rd(1);
      $display("foreign address done");
      @(posedge core_clk);
      do_reset();
      rd(1);
      chk({pin_oe, pin_out}, 8'h0F);
      $display("second reset done");
      test_done();
   end
endmodule // ifbio_expander_tb
